//--- src/fws_pkg.sv
// Constants shared by the flash status controller and its cycle engine
package fws_pkg;
  // Flash bus shape
  localparam int FL_AW = 20;
  localparam int FL_DW = 8;
  // Bus timing, in ns, and derived cycle counts at mclk
  localparam int CLK_NS   = 8;
  localparam int T_RC_NS  = 70;
  localparam int T_WP_NS  = 35;
  localparam int T_REC_NS = 20;
  localparam int SYNC_LAT = 2;
  localparam int RD_CYC   = (T_RC_NS + CLK_NS - 1) / CLK_NS + SYNC_LAT;
  localparam int WR_CYC   = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int REC_CYC  = (T_REC_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [4:0] RD_CNT  = 5'(RD_CYC - 1);
  localparam logic [4:0] WR_CNT  = 5'(WR_CYC - 1);
  localparam logic [4:0] REC_CNT = 5'(REC_CYC - 1);
  // Register offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_ISTAT  = 8'h10;
  localparam logic [7:0] REG_IMASK  = 8'h14;
  // Operation codes in CTRL[2:0]
  localparam logic [2:0] OP_NONE = 3'h0;
  localparam logic [2:0] OP_PROG = 3'h1;
  localparam logic [2:0] OP_SEC  = 3'h2;
  localparam logic [2:0] OP_CHIP = 3'h3;
  localparam logic [2:0] OP_SUSP = 3'h4;
  localparam logic [2:0] OP_RST  = 3'h5;
  localparam logic [2:0] OP_ADD  = 3'h6;
  localparam logic [2:0] OP_POLL = 3'h7;
  // Flash commands
  localparam logic [FL_AW-1:0] UNLK_A1 = 20'h00555;
  localparam logic [FL_AW-1:0] UNLK_A2 = 20'h002AA;
  localparam logic [7:0] CMD_UNLK1 = 8'hAA;
  localparam logic [7:0] CMD_UNLK2 = 8'h55;
  localparam logic [7:0] CMD_PROG  = 8'hA0;
  localparam logic [7:0] CMD_ERASE = 8'h80;
  localparam logic [7:0] CMD_SEC   = 8'h30;
  localparam logic [7:0] CMD_CHIP  = 8'h10;
  localparam logic [7:0] CMD_SUSP  = 8'hB0;
  localparam logic [7:0] CMD_RESET = 8'hF0;
  // Status bit positions on the data bus
  localparam int DATA_POLLING_BIT    = 7;
  localparam int FIRST_TOGGLE_BIT    = 6;
  localparam int TIMING_EXCEEDED_BIT = 5;
  localparam int ERASE_WINDOW_BIT    = 3;
  localparam int SECOND_TOGGLE_BIT   = 2;
  // Interrupt status layout
  localparam int IRQ_DONE = 0;
  localparam int IRQ_FAIL = 1;
  localparam int IRQ_WIN  = 2;
  localparam int IRQ_REJ  = 3;
  localparam int IRQ_W    = 4;
  localparam logic [IRQ_W-1:0] IMASK_RST = 4'h0;
endpackage

//--- src/fws_cyc_if.sv
// Request and answer signals between sequencer and flash cycle engine
`timescale 1ns/100ps
`default_nettype none
interface fws_cyc_if;
  import fws_pkg::*;
  logic             req;
  logic             wr;
  logic [FL_AW-1:0] addr;
  logic [FL_DW-1:0] wdata;
  logic [FL_DW-1:0] rdata;
  logic             done;
  logic             idle;
  modport ctl (output req, wr, addr, wdata, input rdata, done, idle);
  modport eng (input req, wr, addr, wdata, output rdata, done, idle);
endinterface
`default_nettype wire

//--- src/fws_cycle.sv
// One asynchronous flash read or write cycle on the device pins
`timescale 1ns/100ps
`default_nettype none
module fws_cycle
  import fws_pkg::*;
(
  input  wire logic             mclk,
  input  wire logic             rst_n,
  fws_cyc_if.eng                cyc,
  output logic                  flash_ce_n,
  output logic                  flash_oe_n,
  output logic                  flash_we_n,
  output logic [fws_pkg::FL_AW-1:0] flash_addr,
  input  wire logic [fws_pkg::FL_DW-1:0] dq_in,
  output logic [fws_pkg::FL_DW-1:0] dq_out,
  output logic                  dq_oe
);
  import fws_pkg::*;

  typedef enum logic [2:0] {
    ENG_IDLE = 3'b001,
    ENG_ACT  = 3'b010,
    ENG_REC  = 3'b100
  } fws_eng_t;

  fws_eng_t         state_ff;
  logic [4:0]       cnt_ff;
  logic [FL_DW-1:0] dq_s1_ff;
  logic [FL_DW-1:0] dq_s2_ff;
  logic [FL_DW-1:0] rdata_ff;
  logic             done_ff;

  assign cyc.idle  = (state_ff == ENG_IDLE);
  assign cyc.rdata = rdata_ff;
  assign cyc.done  = done_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Data pins pass two flops; the read window is stretched to cover them
  always_ff @(posedge mclk) begin
    dq_s1_ff <= dq_in;
    dq_s2_ff <= dq_s1_ff;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_ff   <= ENG_IDLE;
      cnt_ff     <= 5'h00;
      flash_ce_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_addr <= '0;
      dq_out     <= '0;
      dq_oe      <= 1'b0;
      rdata_ff   <= '0;
      done_ff    <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      case (state_ff)
        ENG_IDLE: begin
          if (cyc.req) begin
            flash_addr <= cyc.addr;
            dq_out     <= cyc.wdata;
            dq_oe      <= cyc.wr;
            flash_ce_n <= 1'b0;
            flash_oe_n <= cyc.wr;
            flash_we_n <= ~cyc.wr;
            cnt_ff     <= cyc.wr ? WR_CNT : RD_CNT;
            state_ff   <= ENG_ACT;
          end
        end
        ENG_ACT: begin
          if (cnt_ff == 5'h00) begin
            rdata_ff   <= dq_s2_ff;
            flash_ce_n <= 1'b1;
            flash_oe_n <= 1'b1;
            flash_we_n <= 1'b1;
            cnt_ff     <= REC_CNT;
            state_ff   <= ENG_REC;
          end else begin
            cnt_ff <= cnt_ff - 5'h01;
          end
        end
        ENG_REC: begin
          // Data stays driven through recovery to cover write hold time
          if (cnt_ff == 5'h00) begin
            dq_oe    <= 1'b0;
            done_ff  <= 1'b1;
            state_ff <= ENG_IDLE;
          end else begin
            cnt_ff <= cnt_ff - 5'h01;
          end
        end
        default: state_ff <= ENG_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

//--- src/fws_top.sv
// Host controller that commands a parallel flash and tracks its status bits
//
// Local design decisions: the address map and strobed register access.
`timescale 1ns/100ps
`default_nettype none
module fws_top
  import fws_pkg::*;
(
  input  wire logic                      mclk,
  input  wire logic                      rst_n,
  input  wire logic [7:0]                reg_addr,
  input  wire logic [31:0]               reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic [31:0]                    reg_rdata,
  output logic                           irq,
  output logic                           flash_ce_n,
  output logic                           flash_oe_n,
  output logic                           flash_we_n,
  output logic [fws_pkg::FL_AW-1:0]      flash_addr,
  input  wire logic [fws_pkg::FL_DW-1:0] dq_in,
  output logic [fws_pkg::FL_DW-1:0]      dq_out,
  output logic                           dq_oe,
  input  wire logic                      ready_busy_out
);
  import fws_pkg::*;

  typedef enum logic [8:0] {
    S_IDLE  = 9'b000000001,
    S_WR    = 9'b000000010,
    S_RD1   = 9'b000000100,
    S_RD2   = 9'b000001000,
    S_CHK   = 9'b000010000,
    S_WPRE  = 9'b000100000,
    S_WPOST = 9'b001000000,
    S_WIN   = 9'b010000000,
    S_RST   = 9'b100000000
  } fws_state_t;

  fws_cyc_if cyc ();

  fws_state_t       state_ff;
  logic [2:0]       op_ff;
  logic [2:0]       idx_ff;
  logic             issued_ff;
  logic             recheck_ff;
  logic [FL_AW-1:0] addr_ff;
  logic [FL_DW-1:0] wdata_ff;
  logic [FL_DW-1:0] st1_ff;
  logic [FL_DW-1:0] st2_ff;
  logic             win_ff;
  logic [IRQ_W-1:0] istat_ff;
  logic [IRQ_W-1:0] imask_ff;
  logic [IRQ_W-1:0] ev;
  logic             rb_s1_ff;
  logic             rb_s2_ff;
  logic             need_cyc;
  logic             tog1;
  logic             tog2;
  logic [FL_AW+FL_DW-1:0] ent;

  ////////////////////////////////////////////////////////////////////////////
  // Command sequence table
  function automatic logic [FL_AW+FL_DW-1:0] seq_ent(
    input logic [2:0]       op,
    input logic [2:0]       idx,
    input logic [FL_AW-1:0] a,
    input logic [FL_DW-1:0] d
  );
    logic [FL_AW+FL_DW-1:0] r;
    r = {a, CMD_RESET};
    case (op)
      OP_SUSP: r = {a, CMD_SUSP};
      OP_ADD:  r = {a, CMD_SEC};
      OP_RST:  r = {a, CMD_RESET};
      default: begin
        case (idx)
          3'h0:    r = {UNLK_A1, CMD_UNLK1};
          3'h1:    r = {UNLK_A2, CMD_UNLK2};
          3'h2:    r = {UNLK_A1, (op == OP_PROG) ? CMD_PROG : CMD_ERASE};
          3'h3:    r = (op == OP_PROG) ? {a, d} : {UNLK_A1, CMD_UNLK1};
          3'h4:    r = {UNLK_A2, CMD_UNLK2};
          default: r = (op == OP_CHIP) ? {UNLK_A1, CMD_CHIP} : {a, CMD_SEC};
        endcase
      end
    endcase
    return r;
  endfunction

  function automatic logic [2:0] seq_last(input logic [2:0] op);
    logic [2:0] r;
    r = 3'h0;
    if (op == OP_PROG)
      r = 3'h3;
    else if (op == OP_SEC || op == OP_CHIP)
      r = 3'h5;
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Cycle requests; every status read goes to the latched target address
  assign need_cyc = (state_ff != S_IDLE) && (state_ff != S_CHK);
  assign ent      = seq_ent(op_ff, idx_ff, addr_ff, wdata_ff);
  assign cyc.req  = need_cyc && !issued_ff && cyc.idle;
  assign cyc.wr   = (state_ff == S_WR) || (state_ff == S_RST);
  assign cyc.addr = (state_ff == S_WR) ? ent[FL_AW+FL_DW-1:FL_DW]
                                       : addr_ff;
  assign cyc.wdata = (state_ff == S_RST) ? CMD_RESET : ent[FL_DW-1:0];

  assign tog1 = st1_ff[FIRST_TOGGLE_BIT] ^ st2_ff[FIRST_TOGGLE_BIT];
  assign tog2 = st1_ff[SECOND_TOGGLE_BIT] ^ st2_ff[SECOND_TOGGLE_BIT];

  fws_cycle u_cycle (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .cyc        (cyc.eng),
    .flash_ce_n (flash_ce_n),
    .flash_oe_n (flash_oe_n),
    .flash_we_n (flash_we_n),
    .flash_addr (flash_addr),
    .dq_in      (dq_in),
    .dq_out     (dq_out),
    .dq_oe      (dq_oe)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Ready/busy pin is asynchronous to mclk
  always_ff @(posedge mclk) begin
    rb_s1_ff <= ready_busy_out;
    rb_s2_ff <= rb_s1_ff;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operation sequencer
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_ff   <= S_IDLE;
      op_ff      <= OP_NONE;
      idx_ff     <= 3'h0;
      issued_ff  <= 1'b0;
      recheck_ff <= 1'b0;
      st1_ff     <= '0;
      st2_ff     <= '0;
      win_ff     <= 1'b0;
      ev         <= '0;
    end else begin
      ev <= '0;
      if (cyc.req)
        issued_ff <= 1'b1;
      if (cyc.done)
        issued_ff <= 1'b0;
      case (state_ff)
        S_IDLE: begin
          if (reg_wr && reg_addr == REG_CTRL && reg_wdata[2:0] != OP_NONE) begin
            op_ff      <= reg_wdata[2:0];
            idx_ff     <= 3'h0;
            recheck_ff <= 1'b0;
            if (reg_wdata[2:0] == OP_POLL)
              state_ff <= S_RD1;
            else if (reg_wdata[2:0] == OP_ADD)
              state_ff <= S_WPRE;
            else
              state_ff <= S_WR;
          end
        end
        S_WR: begin
          if (cyc.done) begin
            if (idx_ff != seq_last(op_ff))
              idx_ff <= idx_ff + 3'h1;
            else if (op_ff == OP_RST) begin
              ev[IRQ_DONE] <= 1'b1;
              state_ff     <= S_IDLE;
            end else if (op_ff == OP_ADD)
              state_ff <= S_WPOST;
            else
              state_ff <= S_RD1;
          end
        end
        S_RD1: begin
          if (cyc.done) begin
            st1_ff   <= cyc.rdata;
            state_ff <= S_RD2;
          end
        end
        S_RD2: begin
          if (cyc.done) begin
            st2_ff   <= cyc.rdata;
            state_ff <= S_CHK;
          end
        end
        S_CHK: begin
          if (op_ff == OP_SEC) begin
            // Window bit only means something once acceptance is seen
            state_ff <= tog1 ? S_WIN : S_IDLE;
            ev[IRQ_DONE] <= !tog1;
          end else if (!tog1) begin
            ev[IRQ_DONE] <= 1'b1;
            state_ff     <= S_IDLE;
          end else if (recheck_ff) begin
            ev[IRQ_FAIL] <= 1'b1;
            state_ff     <= S_RST;
          end else begin
            // Toggle may stop just as the timing bit rises: read again
            recheck_ff <= st2_ff[TIMING_EXCEEDED_BIT];
            state_ff   <= S_RD1;
          end
        end
        S_WIN: begin
          if (cyc.done) begin
            win_ff        <= cyc.rdata[ERASE_WINDOW_BIT];
            ev[IRQ_WIN]   <= cyc.rdata[ERASE_WINDOW_BIT];
            ev[IRQ_DONE]  <= 1'b1;
            state_ff      <= S_IDLE;
          end
        end
        S_WPRE: begin
          if (cyc.done) begin
            win_ff <= cyc.rdata[ERASE_WINDOW_BIT];
            if (cyc.rdata[ERASE_WINDOW_BIT]) begin
              // Closed window would drop the command anyway
              ev[IRQ_REJ]  <= 1'b1;
              ev[IRQ_DONE] <= 1'b1;
              state_ff     <= S_IDLE;
            end else begin
              state_ff <= S_WR;
            end
          end
        end
        S_WPOST: begin
          if (cyc.done) begin
            win_ff       <= cyc.rdata[ERASE_WINDOW_BIT];
            ev[IRQ_REJ]  <= cyc.rdata[ERASE_WINDOW_BIT];
            ev[IRQ_DONE] <= 1'b1;
            state_ff     <= S_IDLE;
          end
        end
        S_RST: begin
          if (cyc.done) begin
            ev[IRQ_DONE] <= 1'b1;
            state_ff     <= S_IDLE;
          end
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Target address and program data
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      addr_ff  <= '0;
      wdata_ff <= '0;
    end else if (reg_wr) begin
      if (reg_addr == REG_ADDR)
        addr_ff <= reg_wdata[FL_AW-1:0];
      if (reg_addr == REG_WDATA)
        wdata_ff <= reg_wdata[FL_DW-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky events; a new event wins over a write-one clear
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      istat_ff <= '0;
      imask_ff <= IMASK_RST;
    end else begin
      if (reg_wr && reg_addr == REG_ISTAT)
        istat_ff <= (istat_ff & ~reg_wdata[IRQ_W-1:0]) | ev;
      else
        istat_ff <= istat_ff | ev;
      if (reg_wr && reg_addr == REG_IMASK)
        imask_ff <= reg_wdata[IRQ_W-1:0];
    end
  end

  assign irq = |(istat_ff & imask_ff);

  ////////////////////////////////////////////////////////////////////////////
  // Read port, data one cycle after the strobe
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_CTRL:   reg_rdata <= {29'h0, op_ff};
        REG_ADDR:   reg_rdata <= {12'h000, addr_ff};
        REG_WDATA:  reg_rdata <= {24'h000000, wdata_ff};
        // Decoded view of the last two status reads
        REG_STATUS: reg_rdata <= {8'h00, st1_ff, st2_ff,
                                  1'b0,
                                  st2_ff[DATA_POLLING_BIT] && !tog1 && tog2,
                                  !st2_ff[DATA_POLLING_BIT] && tog1 && tog2,
                                  tog2, tog1, win_ff, rb_s2_ff,
                                  state_ff != S_IDLE};
        REG_ISTAT:  reg_rdata <= {28'h0000000, istat_ff};
        REG_IMASK:  reg_rdata <= {28'h0000000, imask_ff};
        default:    reg_rdata <= 32'h00000000;
      endcase
    end
  end
endmodule
`default_nettype wire

//--- testbench/fws_top_props.sv
// Checker of flash strobe timing and register port behaviour
`timescale 1ns/100ps
`default_nettype none
module fws_top_props
  import fws_pkg::*;
(
  input wire logic                      mclk,
  input wire logic                      rst_n,
  input wire logic [7:0]                reg_addr,
  input wire logic                      reg_rd,
  input wire logic [31:0]               reg_rdata,
  input wire logic                      irq,
  input wire logic                      flash_ce_n,
  input wire logic                      flash_oe_n,
  input wire logic                      flash_we_n,
  input wire logic [fws_pkg::FL_AW-1:0] flash_addr,
  input wire logic [fws_pkg::FL_DW-1:0] dq_out,
  input wire logic                      dq_oe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////
  reset_idle_a: assert property (disable iff (1'b0) !rst_n |=> flash_ce_n &&
    flash_oe_n && flash_we_n && !dq_oe && !irq && reg_rdata == 32'h0)
    else $error("bus not idle after reset");
  strobe_excl_a: assert property (flash_oe_n || flash_we_n)
    else $error("read and write strobes low together");
  chip_sel_a: assert property ((!flash_oe_n || !flash_we_n) |-> !flash_ce_n)
    else $error("strobe without chip enable");
  no_contend_a: assert property (!flash_oe_n |-> !dq_oe)
    else $error("data driven during read");
  // Address checked stable over the first 9 of the 11 read cycles so status comes from one location
  rd_len_a: assert property ($fell(flash_oe_n) |=>
    (!flash_oe_n && $stable(flash_addr))[*8] ##1 (!flash_oe_n)[*2]
    ##1 flash_oe_n) else $error("read low phase not 11 cycles");
  wr_len_a: assert property ($fell(flash_we_n) |=>
    (!flash_we_n && dq_oe && $stable(dq_out))[*4] ##1 flash_we_n)
    else $error("write pulse not 5 cycles");
  recovery_a: assert property (($rose(flash_oe_n) || $rose(flash_we_n)) |->
    (flash_oe_n && flash_we_n)[*3]) else $error("recovery too short");
  rdata_hold_a: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data changed without read");
  unmapped_a: assert property (reg_rd && reg_addr == 8'h20 |=>
    reg_rdata == 32'h0) else $error("unmapped read not zero");
endmodule

bind fws_top fws_top_props i_fws_top_props (
  .mclk       (mclk),
  .rst_n      (rst_n),
  .reg_addr   (reg_addr),
  .reg_rd     (reg_rd),
  .reg_rdata  (reg_rdata),
  .irq        (irq),
  .flash_ce_n (flash_ce_n),
  .flash_oe_n (flash_oe_n),
  .flash_we_n (flash_we_n),
  .flash_addr (flash_addr),
  .dq_out     (dq_out),
  .dq_oe      (dq_oe)
);
`default_nettype wire

//--- testbench/fws_flash_model.sv
// Behavioural parallel flash with program, erase and status reporting
`timescale 1ns/100ps
`default_nettype none
module fws_flash_model
  import fws_pkg::*;
#(
  parameter int PROG_NS  = 1500,
  parameter int WIN_NS   = 3000,
  parameter int ERASE_NS = 5000
)
(
  input  wire logic                      ce_n,
  input  wire logic                      oe_n,
  input  wire logic                      we_n,
  input  wire logic [fws_pkg::FL_AW-1:0] addr,
  input  wire logic [fws_pkg::FL_DW-1:0] din,
  output logic [fws_pkg::FL_DW-1:0]      dout,
  output logic                           rdy
);
  // States: 0 idle, 1 program, 2 window, 3 erasing, 4 suspended, 5 failed
  int          st = 0;
  int          seq = 0;
  bit          bad = 0;
  bit          reset_seen = 0;
  logic        tgl_first = 1'b0;
  logic        tgl_second = 1'b0;
  logic [7:0]  pd = 8'h00;
  logic [7:0]  arr [int];
  realtime     t_end = 0;
  // Strobes release together, so select is taken as the pulse opens
  bit          wr_sel = 0;

  function automatic logic [7:0] rd(input logic [FL_AW-1:0] a);
    return arr.exists(int'(a)) ? arr[int'(a)] : 8'hFF;
  endfunction

  assign rdy = (st == 0 || st == 4);
  initial dout = 8'h00;

  ////////////////////////////////////////////////////////////////////////
  always @(negedge we_n) wr_sel = !ce_n;

  always @(posedge we_n) if (wr_sel) begin
    if (st == 3) begin
      if (din == CMD_SUSP) st = 4;
    end else if (st == 2) begin
      // Open window takes another sector and restarts the whole time-out
      if (din == CMD_SEC) t_end = $realtime + WIN_NS;
    end else if (st == 5 || st == 4) begin
      if (din == CMD_RESET) begin
        reset_seen = (st == 5);
        st = 0;
      end
    end else if (st == 0) begin
      case (seq)
        0: seq = (din == CMD_UNLK1 && addr == UNLK_A1) ? 1 : 0;
        1: seq = (din == CMD_UNLK2 && addr == UNLK_A2) ? 2 : 0;
        2: seq = (din == CMD_PROG) ? 10 : (din == CMD_ERASE) ? 3 : 0;
        3: seq = (din == CMD_UNLK1 && addr == UNLK_A1) ? 4 : 0;
        4: seq = (din == CMD_UNLK2 && addr == UNLK_A2) ? 5 : 0;
        5: begin
          seq = 0;
          if (din == CMD_SEC) begin
            st = 2;
            t_end = $realtime + WIN_NS;
          end else if (din == CMD_CHIP && addr == UNLK_A1) begin
            st = 3;
            t_end = $realtime + ERASE_NS;
          end
        end
        10: begin
          // A 1 over a 0 cannot be programmed and ends in a time-out
          bad = |(din & ~rd(addr));
          arr[int'(addr)] = rd(addr) & din;
          pd = din;
          st = 1;
          seq = 0;
          t_end = $realtime + PROG_NS;
        end
        default: seq = 0;
      endcase
    end
  end

  always begin
    #20;
    if ($realtime >= t_end) begin
      if (st == 1) st = bad ? 5 : 0;
      else if (st == 2) begin
        st = 3;
        t_end = $realtime + ERASE_NS;
      end else if (st == 3) begin
        st = 0;
        arr.delete();
      end
    end
  end

  always @(negedge oe_n) if (!ce_n) begin
    if (st != 0 && st != 4) tgl_first = ~tgl_first;
    if (st >= 2) tgl_second = ~tgl_second;
    case (st)
      1: dout = {~pd[7], tgl_first, 6'h00};
      5: dout = {~pd[7], tgl_first, 1'b1, 5'h00};
      2, 3: dout = {1'b0, tgl_first, 2'b00, st == 3, tgl_second, 2'b00};
      4: dout = {1'b1, tgl_first, 3'b000, tgl_second, 2'b00};
      default: dout = rd(addr);
    endcase
  end

  // Released bus: no pull, so show a changed value rather than the last one
  always @(posedge oe_n) dout = ~dout;
endmodule
`default_nettype wire

//--- testbench/fws_top_tb.sv
// Self-checking bench of the flash status controller
`timescale 1ns/100ps
`default_nettype none
module fws_top_tb;
  import fws_pkg::*;
  logic             mclk, rst_n, reg_wr, reg_rd, irq;
  logic [7:0]       reg_addr;
  logic [31:0]      reg_wdata, reg_rdata, v;
  logic             ce_n, oe_n, we_n, dq_oe, rdy;
  logic [FL_AW-1:0] fa, a;
  logic [FL_DW-1:0] dq_in, dq_out, d;
  logic [3:0]       msk;
  int               err_count, comparisons, cyc;

  fws_top i_fws_top (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .flash_ce_n(ce_n), .flash_oe_n(oe_n),
    .flash_we_n(we_n), .flash_addr(fa), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe(dq_oe), .ready_busy_out(rdy));
  fws_flash_model i_fws_flash_model (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .addr(fa), .din(dq_out), .dout(dq_in), .rdy(rdy));

  ////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic finish_test;
    if (err_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      finish_test;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
    @(posedge mclk);
    reg_addr <= ad;
    reg_wdata <= dt;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] ad, output logic [31:0] q);
    @(posedge mclk);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask

  // Start an operation, wait for busy to drop, then check and clear events
  task automatic run_op(input logic [2:0] op, input logic [3:0] exp);
    logic [31:0] s;
    int          n;
    wr(REG_ADDR, 32'(a));
    wr(REG_WDATA, 32'(d));
    wr(REG_CTRL, 32'(op));
    s = 32'h1;
    for (n = 0; n < 3000 && s[0] !== 1'b0; n++) rd(REG_STATUS, s);
    rd(REG_ISTAT, s);
    chk(s, 32'(exp));
    chk(32'(irq), 32'(|(exp & msk)));
    wr(REG_ISTAT, 32'hF);
    @(posedge mclk);
    chk(32'(irq), 32'h0);
  endtask

  initial begin
    {reg_wr, reg_rd, reg_addr, reg_wdata, msk} = '0;
    rst_n = 1'b0;
    void'($urandom(32'hd714));
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    rd(REG_IMASK, v);
    chk(v, 32'(IMASK_RST));
    rd(8'h20, v);
    chk(v, 32'h0);
    a = 20'h01000 | 20'($urandom & 32'hFF0);
    d = 8'($urandom) & 8'h7F;
    run_op(OP_PROG, 4'h1);
    msk = 4'hF;
    wr(REG_IMASK, 32'(msk));
    d = d | 8'h80;
    run_op(OP_PROG, 4'h3);
    chk(32'(i_fws_flash_model.reset_seen), 32'h1);
    run_op(OP_SEC, 4'h1);
    rd(REG_STATUS, v);
    chk(v & 32'h3C, 32'h38);
    repeat (250) @(posedge mclk);
    run_op(OP_ADD, 4'h1);
    repeat (250) @(posedge mclk);
    run_op(OP_ADD, 4'h1);
    repeat (500) @(posedge mclk);
    run_op(OP_ADD, 4'h9);
    run_op(OP_SUSP, 4'h1);
    rd(REG_STATUS, v);
    chk(v & 32'h42, 32'h42);
    run_op(OP_RST, 4'h1);
    run_op(OP_CHIP, 4'h1);
    run_op(OP_PROG, 4'h1);
    run_op(OP_POLL, 4'h1);
    repeat (3) begin
      a = 20'h20000 | 20'($urandom & 32'hFFFF);
      d = 8'($urandom);
      run_op(OP_PROG, 4'h1);
    end
    finish_test;
  end
endmodule
`default_nettype wire
